/* hw/mbrtu_pkg.sv */
// Constants, baud table and frame-check helper for the serial slave framer.
// Assumes a single clock domain; no software-visible registers.
package mbrtu_pkg;
   localparam int             OVS         = 16;       // Samples per bit
   localparam int             CHAR_BITS   = 11;       // Start, 8 data, 2 stop
   localparam int             SIL_TICKS   = 35 * CHAR_BITS * OVS / 10;
   localparam int             NUM_RATES   = 10;
   localparam logic [7:0]     ADDR_BCAST  = 8'h00;
   localparam logic [7:0]     ADDR_MAX    = 8'hf7;
   localparam logic [15:0]    CRC_SEED    = 16'hffff;
   localparam logic [15:0]    CRC_POLY    = 16'ha001;
   localparam logic [15:0]    CRC_RESID   = 16'h0000;
   localparam logic [7:0]     EXC_BIT     = 8'h80;
   localparam int             MIN_FRAME   = 4;

   function automatic int baud_of(input logic [3:0] sel);
      case (sel)
         4'h0:    baud_of = 600;
         4'h1:    baud_of = 1200;
         4'h2:    baud_of = 2400;
         4'h3:    baud_of = 4800;
         4'h4:    baud_of = 9600;
         4'h5:    baud_of = 19200;
         4'h6:    baud_of = 38400;
         4'h7:    baud_of = 57600;
         4'h8:    baud_of = 76800;
         default: baud_of = 115200;
      endcase
   endfunction

   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      crc_step = c;
   endfunction
endpackage

/* hw/mbrtu_uart_rx.sv */
// Character receiver sampling a synchronised line at sixteen ticks per bit.
// Assumes the tick pulse comes from the framer's baud divider.
`timescale 1ns/1ps
`default_nettype none
module mbrtu_uart_rx (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       ce,
   input  wire logic       tick,
   input  wire logic       rxPin,
   output logic            busy,
   output logic [7:0]      rxByte,
   output logic            rxStrobe,
   output logic            rxErr
);
   typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} rst_e;
   typedef struct packed {
      logic       s1;
      logic       s2;
      rst_e       st;
      logic [3:0] cnt;
      logic [2:0] bitIdx;
      logic [7:0] sh;
      logic [7:0] data;
      logic       strobe;
      logic       err;
   } rx_s;
   rx_s cur_r, cur_nxt;

   always_comb begin
      cur_nxt        = cur_r;
      cur_nxt.s1     = rxPin;
      cur_nxt.s2     = cur_r.s1;
      cur_nxt.strobe = 1'b0;
      cur_nxt.err    = 1'b0;
      if (tick) begin
         cur_nxt.cnt = cur_r.cnt + 4'h1;
         case (cur_r.st)
            R_IDLE: begin
               cur_nxt.cnt = 4'h0;
               if (!cur_r.s2) cur_nxt.st = R_START;
            end
            R_START: begin
               if (cur_r.cnt == 4'h7) begin
                  cur_nxt.cnt = 4'h0;
                  cur_nxt.st  = cur_r.s2 ? R_IDLE : R_DATA;   // Glitch rejected
               end
            end
            R_DATA: begin
               if (cur_r.cnt == 4'hf) begin
                  cur_nxt.sh     = {cur_r.s2, cur_r.sh[7:1]};
                  cur_nxt.bitIdx = cur_r.bitIdx + 3'h1;
                  if (cur_r.bitIdx == 3'h7) cur_nxt.st = R_STOP;
               end
            end
            R_STOP: begin
               // Back to idle at mid first stop, so one or two stops both work
               if (cur_r.cnt == 4'hf) begin
                  cur_nxt.st     = R_IDLE;
                  cur_nxt.data   = cur_r.sh;
                  cur_nxt.strobe = cur_r.s2;
                  cur_nxt.err    = !cur_r.s2;
               end
            end
            default: cur_nxt.st = R_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cur_r <= '{s1: 1'b1, s2: 1'b1, st: R_IDLE, default: '0};
      end else if (ce) begin
         cur_r <= cur_nxt;
      end
   end

   assign busy     = (cur_r.st != R_IDLE) || !cur_r.s2;
   assign rxByte   = cur_r.data;
   assign rxStrobe = cur_r.strobe;
   assign rxErr    = cur_r.err;
endmodule // mbrtu_uart_rx
`default_nettype wire

/* hw/mbrtu_uart_tx.sv */
// Character transmitter: start, eight data LSB first, two stop bits.
// Assumes the tick pulse comes from the framer's baud divider.
`timescale 1ns/1ps
`default_nettype none
module mbrtu_uart_tx (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       ce,
   input  wire logic       tick,
   input  wire logic       load,
   input  wire logic [7:0] txByte,
   output logic            ready,
   output logic            txPin
);
   typedef struct packed {
      logic       busy;
      logic [3:0] cnt;
      logic [3:0] bitIdx;
      logic [10:0] sh;
   } tx_s;
   tx_s cur_r, cur_nxt;

   always_comb begin
      cur_nxt = cur_r;
      if (!cur_r.busy) begin
         if (load) begin
            cur_nxt.busy   = 1'b1;
            cur_nxt.cnt    = 4'h0;
            cur_nxt.bitIdx = 4'h0;
            cur_nxt.sh     = {2'b11, txByte, 1'b0};
         end
      end else if (tick) begin
         cur_nxt.cnt = cur_r.cnt + 4'h1;
         if (cur_r.cnt == 4'hf) begin
            cur_nxt.sh     = {1'b1, cur_r.sh[10:1]};
            cur_nxt.bitIdx = cur_r.bitIdx + 4'h1;
            if (cur_r.bitIdx == 4'(mbrtu_pkg::CHAR_BITS - 1)) cur_nxt.busy = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cur_r <= '{sh: 11'h7ff, default: '0};
      end else if (ce) begin
         cur_r <= cur_nxt;
      end
   end

   assign ready = !cur_r.busy;
   assign txPin = cur_r.sh[0];
endmodule // mbrtu_uart_tx
`default_nettype wire

/* hw/modbus_rtu_slave_framer.sv */
// Slave framer: frame delimiting by silence, check, address filter, reply timing.
// Assumes a two-wire transceiver: lineIn from the pin, lineOut/lineOe drive it.
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_slave_framer #(
   parameter int CLK_HZ = 100_000_000
) (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       ce,
   input  wire logic [3:0] baudSel,
   input  wire logic [7:0] nodeAddr,
   input  wire logic [15:0] maxRespBits,
   input  wire logic       lineIn,
   output logic            lineOut,
   output logic            lineOe,
   output logic [7:0]      reqData,
   output logic            reqValid,
   output logic            reqEnd,
   output logic            reqOk,
   output logic            reqBcast,
   input  wire logic [7:0] respData,
   input  wire logic       respValid,
   input  wire logic       respLast,
   input  wire logic       respExc,
   output logic            respReady,
   output logic            respTimeout,
   output logic            respDone
);
   // Divider needs two cycles per sample tick at the top rate
   if (CLK_HZ / (mbrtu_pkg::OVS * 115200) < 2) begin : g_clkLow
      $error("CLK_HZ too low for fastest rate");
   end
   // Divider is sixteen bits wide at the slowest rate
   if (CLK_HZ / (mbrtu_pkg::OVS * 600) > 65535) begin : g_clkHigh
      $error("CLK_HZ too high for divider");
   end

   typedef enum logic [2:0] {T_IDLE, T_WAIT, T_ADDR, T_PAY, T_CRCLO, T_CRCHI, T_DRAIN} tst_e;
   typedef struct packed {
      logic [15:0] div;
      logic        tick;
      logic [9:0]  sil;
      logic        inFrame;
      logic [7:0]  cnt;
      logic        bad;
      logic        mine;
      logic        bcast;
      logic [15:0] rcrc;
      logic [7:0]  outData;
      logic        outValid;
      logic        endP;
      logic        okP;
      logic        bcP;
      tst_e        ts;
      logic [3:0]  bitTick;
      logic [15:0] respBits;
      logic [15:0] tcrc;
      logic        firstPay;
      logic        toP;
      logic        doneP;
   } fr_s;
   fr_s cur_r, cur_nxt;

   logic [7:0] rxByte;
   logic       rxStrobe;
   logic       rxErr;
   logic       rxBusy;
   logic       txReady;
   logic       txLoad;
   logic [7:0] txByte;
   logic       txPin;

   function automatic logic [15:0] div_of(input logic [3:0] sel);
      div_of = 16'(CLK_HZ / (mbrtu_pkg::OVS * mbrtu_pkg::baud_of(sel)) - 1);
   endfunction

   function automatic logic addr_valid(input logic [7:0] a);
      addr_valid = (a != mbrtu_pkg::ADDR_BCAST) && (a <= mbrtu_pkg::ADDR_MAX);
   endfunction

   mbrtu_uart_rx u_rx (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .ce       (ce),
      .tick     (cur_r.tick),
      .rxPin    (lineIn),
      .busy     (rxBusy),
      .rxByte   (rxByte),
      .rxStrobe (rxStrobe),
      .rxErr    (rxErr)
   );

   mbrtu_uart_tx u_tx (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .ce       (ce),
      .tick     (cur_r.tick),
      .load     (txLoad),
      .txByte   (txByte),
      .ready    (txReady),
      .txPin    (txPin)
   );

   logic txActive;
   logic ownEcho;
   logic silDone;
   assign txActive = (cur_r.ts inside {T_ADDR, T_PAY, T_CRCLO, T_CRCHI, T_DRAIN}) || !txReady;
   // Own transmission echoes back on a two-wire bus; it must not count as a request
   assign ownEcho  = txActive;
   assign silDone  = (cur_r.sil >= 10'(mbrtu_pkg::SIL_TICKS));

   always_comb begin
      cur_nxt          = cur_r;
      cur_nxt.outValid = 1'b0;
      cur_nxt.endP     = 1'b0;
      cur_nxt.toP      = 1'b0;
      cur_nxt.doneP    = 1'b0;
      txLoad           = 1'b0;
      txByte           = respData;
      respReady        = 1'b0;

      // Baud divider, rate chosen live from the selector
      cur_nxt.tick = 1'b0;
      if (cur_r.div == 16'h0000) begin
         cur_nxt.div  = div_of(baudSel);
         cur_nxt.tick = 1'b1;
      end else begin
         cur_nxt.div = cur_r.div - 16'h0001;
      end

      // Silence measured in sample ticks, restarted by any line activity
      if (rxBusy || txActive) begin
         cur_nxt.sil = 10'h000;
      end else if (cur_r.tick && !silDone) begin
         cur_nxt.sil = cur_r.sil + 10'h001;
      end

      if (rxStrobe || rxErr) begin
         if (!ownEcho) begin
            cur_nxt.inFrame = 1'b1;
            cur_nxt.cnt     = (cur_r.cnt == 8'hff) ? cur_r.cnt : cur_r.cnt + 8'h01;
            cur_nxt.bad     = cur_r.bad | rxErr;
            cur_nxt.rcrc    = mbrtu_pkg::crc_step(cur_r.rcrc, rxByte);
            if (cur_r.cnt == 8'h00) begin
               cur_nxt.bcast = (rxByte == mbrtu_pkg::ADDR_BCAST);
               cur_nxt.mine  = (rxByte == mbrtu_pkg::ADDR_BCAST) ||
                               (addr_valid(nodeAddr) && rxByte == nodeAddr);
            end else if (cur_r.mine && !rxErr) begin
               cur_nxt.outData  = rxByte;
               cur_nxt.outValid = 1'b1;
            end
         end
      end else if (cur_r.inFrame && silDone) begin
         // Early end from a gap leaves a short or corrupt frame: check fails, no reply
         cur_nxt.inFrame = 1'b0;
         cur_nxt.endP    = 1'b1;
         cur_nxt.okP     = cur_r.mine && !cur_r.bad && (cur_r.rcrc == mbrtu_pkg::CRC_RESID) &&
                           (cur_r.cnt >= 8'(mbrtu_pkg::MIN_FRAME));
         cur_nxt.bcP     = cur_r.bcast;
         cur_nxt.cnt     = 8'h00;
         cur_nxt.bad     = 1'b0;
         cur_nxt.rcrc    = mbrtu_pkg::CRC_SEED;
         cur_nxt.mine    = 1'b0;
         cur_nxt.bcast   = 1'b0;
         if (cur_nxt.okP && !cur_r.bcast && cur_r.ts == T_IDLE) begin
            cur_nxt.ts      = T_WAIT;
            cur_nxt.respBits = 16'h0000;
            cur_nxt.bitTick = 4'h0;
         end
      end

      // Response time counted in bit times from the detected end of request
      if (cur_r.tick && cur_r.ts == T_WAIT) begin
         cur_nxt.bitTick = cur_r.bitTick + 4'h1;
         if (cur_r.bitTick == 4'hf) cur_nxt.respBits = cur_r.respBits + 16'h0001;
      end

      case (cur_r.ts)
         T_IDLE: ;
         T_WAIT: begin
            if (cur_r.respBits >= maxRespBits) begin
               cur_nxt.ts  = T_IDLE;
               cur_nxt.toP = 1'b1;
            end else if (respValid && silDone && txReady && !rxBusy) begin
               // Request end was seen only after the silence, so this gap is already met
               txLoad           = 1'b1;
               txByte           = nodeAddr;
               cur_nxt.tcrc     = mbrtu_pkg::crc_step(mbrtu_pkg::CRC_SEED, nodeAddr);
               cur_nxt.firstPay = 1'b1;
               cur_nxt.ts       = T_PAY;
            end
         end
         T_PAY: begin
            respReady = txReady;
            if (respValid && txReady) begin
               txLoad           = 1'b1;
               txByte           = cur_r.firstPay && respExc ? (respData | mbrtu_pkg::EXC_BIT)
                                                            : respData;
               cur_nxt.tcrc     = mbrtu_pkg::crc_step(cur_r.tcrc, txByte);
               cur_nxt.firstPay = 1'b0;
               if (respLast) cur_nxt.ts = T_CRCLO;
            end
         end
         T_CRCLO: begin
            if (txReady) begin
               txLoad     = 1'b1;
               txByte     = cur_r.tcrc[7:0];
               cur_nxt.ts = T_CRCHI;
            end
         end
         T_CRCHI: begin
            if (txReady) begin
               txLoad     = 1'b1;
               txByte     = cur_r.tcrc[15:8];
               cur_nxt.ts = T_DRAIN;
            end
         end
         T_DRAIN: begin
            if (txReady && !txLoad) begin
               cur_nxt.ts    = T_IDLE;
               cur_nxt.doneP = 1'b1;
            end
         end
         default: cur_nxt.ts = T_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cur_r <= '{rcrc: mbrtu_pkg::CRC_SEED, ts: T_IDLE, default: '0};
      end else if (ce) begin
         cur_r <= cur_nxt;
      end
   end

   // Gaps between reply bytes come only from a stalling user side
   assign lineOut     = txPin;
   assign lineOe      = txActive && (cur_r.ts != T_WAIT);
   assign reqData     = cur_r.outData;
   assign reqValid    = cur_r.outValid;
   assign reqEnd      = cur_r.endP;
   assign reqOk       = cur_r.okP;
   assign reqBcast    = cur_r.bcP;
   assign respTimeout = cur_r.toP;
   assign respDone    = cur_r.doneP;
endmodule // modbus_rtu_slave_framer
`default_nettype wire

/* test/mbrtu_master_model.sv */
// Bus master model: sends request characters, decodes slave replies.
// Assumes the bench resolves the shared line and sets bitCyc.
`timescale 1ns/1ps
`default_nettype none
module mbrtu_master_model (
   input  wire logic mclk,
   input  wire logic busLine,
   input  wire logic slaveOe,
   output var logic  txLine
);
   int         bitCyc = 32;
   int         stopBad = 0;
   logic [7:0] rxQ[$];
   initial txLine = 1'b1;
   function automatic logic [15:0] crcAdd(input logic [15:0] c, input logic [7:0] d);
      c = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      return c;
   endfunction
   task automatic sendByte(input logic [7:0] b, input int stops);
      logic [10:0] sh;
      sh = {2'b11, b, 1'b0};
      for (int i = 0; i < 9 + stops; i++) begin
         txLine = sh[i];
         repeat (bitCyc) @(negedge mclk);
      end
   endtask
   // Back to back unless a five-character gap is asked for
   task automatic sendFrame(input logic [7:0] q[$], input int stops, input int gapAt);
      foreach (q[i]) begin
         if (i == gapAt) repeat (55 * bitCyc) @(negedge mclk);
         sendByte(q[i], stops);
      end
   endtask
   always begin : rxDecode
      logic [7:0] b;
      @(negedge busLine iff slaveOe);
      repeat (bitCyc / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         repeat (bitCyc) @(posedge mclk);
         b[i] = busLine;
      end
      repeat (2) begin
         repeat (bitCyc) @(posedge mclk);
         if (busLine !== 1'b1) stopBad++;
      end
      rxQ.push_back(b);
   end
endmodule // mbrtu_master_model
`default_nettype wire

/* test/modbus_rtu_slave_framer_sva.sv */
// Port checker for the serial slave framer, bound to every instance.
// Assumes one clock domain and a rate held constant during a frame.
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_slave_framer_sva #(
   parameter int CLK_HZ = 100_000_000
) (
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic        ce,
   input wire logic [3:0]  baudSel,
   input wire logic [15:0] maxRespBits,
   input wire logic        lineIn,
   input wire logic        lineOut,
   input wire logic        lineOe,
   input wire logic        reqValid,
   input wire logic        reqEnd,
   input wire logic        reqOk,
   input wire logic        reqBcast,
   input wire logic        respTimeout,
   input wire logic        respDone
);
   localparam int RATE [10] = '{600, 1200, 2400, 4800, 9600, 19200, 38400, 57600, 76800, 115200};
   int   bitLen;
   int   idle_r;
   int   win_r;
   int   hiRun_r;
   logic armed_r;
   assign bitLen = CLK_HZ / (RATE[(baudSel > 4'h9) ? 4'h9 : baudSel] * 16) * 16;
   // Saturates so a long idle line cannot wrap
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         idle_r  <= 0;
         win_r   <= 0;
         hiRun_r <= 0;
         armed_r <= 1'b0;
      end else begin
         idle_r  <= !lineIn ? 0 : (idle_r < 1_000_000) ? idle_r + 1 : idle_r;
         hiRun_r <= !lineOut ? 0 : lineOe ? hiRun_r + 1 : hiRun_r;
         armed_r <= (reqEnd && reqOk && !reqBcast) || (armed_r && !lineOe && !respTimeout);
         // Frozen clock enable also freezes the reply window
         win_r   <= !armed_r ? 0 : ce ? win_r + 1 : win_r;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence s_quiet;
      !lineOe [*8];
   endsequence
   sequence s_startBit;
      ##[0:1] (lineOe && !lineOut);
   endsequence
   property p_txStart; $rose(lineOe) |-> s_startBit; endproperty
   property p_twoStops; respDone |-> hiRun_r >= 2 * bitLen - 2; endproperty
   property p_silence; reqEnd |-> idle_r >= 616 * bitLen / 16; endproperty
   property p_respBound; armed_r |-> win_r <= maxRespBits * bitLen + 8; endproperty
   property p_notEarly; $rose(lineOe) |-> armed_r; endproperty
   property p_bcastQuiet; reqEnd && reqBcast |=> s_quiet; endproperty
   property p_badQuiet; reqEnd && !reqOk |=> s_quiet; endproperty
   property p_halfDuplex; reqValid |-> !lineOe; endproperty
   a_txStart: assert property (p_txStart) else $error("reply lacks start bit");
   a_twoStops: assert property (p_twoStops) else $error("reply stop too short");
   a_silence: assert property (p_silence) else $error("frame end too early");
   a_respBound: assert property (p_respBound) else $error("reply started too late");
   a_notEarly: assert property (p_notEarly) else $error("unrequested reply");
   a_bcastQuiet: assert property (p_bcastQuiet) else $error("broadcast answered");
   a_badQuiet: assert property (p_badQuiet) else $error("refused frame answered");
   a_halfDuplex: assert property (p_halfDuplex) else $error("byte taken while driving");
endmodule // modbus_rtu_slave_framer_sva

bind modbus_rtu_slave_framer modbus_rtu_slave_framer_sva #(.CLK_HZ(CLK_HZ)) i_modbus_rtu_slave_framer_sva (
   .mclk(mclk), .rst_b(rst_b), .ce(ce), .baudSel(baudSel), .maxRespBits(maxRespBits), .lineIn(lineIn),
   .lineOut(lineOut), .lineOe(lineOe), .reqValid(reqValid), .reqEnd(reqEnd), .reqOk(reqOk),
   .reqBcast(reqBcast), .respTimeout(respTimeout), .respDone(respDone));
`default_nettype wire

/* test/modbus_rtu_slave_framer_tb.sv */
// Self-checking bench for the serial slave framer.
// Assumes the master model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_slave_framer_tb;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic        ce = 1'b1;
   logic [3:0]  baudSel = 4'h9;
   logic [15:0] maxRespBits = 16'h00c8;
   logic        lineIn, lineOut, lineOe, txLine, reqValid, reqEnd, reqOk, reqBcast;
   logic        respReady, respTimeout, respDone, lastOk, lastBc;
   logic [7:0]  reqData;
   logic [7:0]  respData = 8'h00;
   logic        respValid = 1'b0, respLast = 1'b0, respExc = 1'b0;
   int          errTotal = 0, numChecks = 0, endCnt = 0, doneCnt = 0, toCnt = 0, cyc = 0, endCyc, toCyc;
   logic [7:0]  gotQ[$];
   always #5 mclk = ~mclk;
   // Divider of two at the top rate keeps the run short
   modbus_rtu_slave_framer #(.CLK_HZ(3_686_400)) i_modbus_rtu_slave_framer (
      .mclk(mclk), .rst_b(rst_b), .ce(ce), .baudSel(baudSel), .nodeAddr(8'h05), .maxRespBits(maxRespBits),
      .lineIn(lineIn), .lineOut(lineOut), .lineOe(lineOe), .reqData(reqData), .reqValid(reqValid),
      .reqEnd(reqEnd), .reqOk(reqOk), .reqBcast(reqBcast), .respData(respData), .respValid(respValid),
      .respLast(respLast), .respExc(respExc), .respReady(respReady), .respTimeout(respTimeout),
      .respDone(respDone));
   mbrtu_master_model i_mbrtu_master_model (.mclk(mclk), .busLine(lineIn), .slaveOe(lineOe), .txLine(txLine));
   assign lineIn = lineOe ? lineOut : txLine;
   always @(negedge mclk) begin
      cyc <= cyc + 1;
      if (reqValid) gotQ.push_back(reqData);
      if (reqEnd) begin
         endCnt <= endCnt + 1;
         endCyc <= cyc;
         lastOk <= reqOk;
         lastBc <= reqBcast;
      end
      if (respDone) doneCnt <= doneCnt + 1;
      if (respTimeout) begin
         toCnt <= toCnt + 1;
         toCyc <= cyc;
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      numChecks++;
      if (got !== exp) begin
         errTotal++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic waitCnt(ref int c, input int n, input string what);
      int k;
      k = 0;
      while (c < n && k < 40000) begin
         @(negedge mclk);
         k++;
      end
      if (c < n) begin
         chk(what, 16'h0001, 16'h0000);
         summarize();
      end
   endtask
   function automatic void addCrc(ref logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i]) c = i_mbrtu_master_model.crcAdd(c, q[i]);
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
   endfunction
   task automatic request(input logic [7:0] q[$], input int stops, gapAt, ends, n, input logic ok, bc);
      repeat (3000) @(negedge mclk);
      addCrc(q);
      gotQ = {};
      endCnt = 0;
      i_mbrtu_master_model.sendFrame(q, stops, gapAt);
      waitCnt(endCnt, ends, "frame end");
      chk("delivered count", 16'(n), 16'(gotQ.size()));
      for (int i = 0; i < n; i++) chk("request byte", {8'h00, q[i + 1]}, {8'h00, gotQ[i]});
      chk("frame ok", {15'h0000, ok}, {15'h0000, lastOk});
      chk("broadcast flag", {15'h0000, bc}, {15'h0000, lastBc});
   endtask
   task automatic reply(input logic [7:0] q[$], input logic exc);
      logic [7:0] e[$];
      e = {8'h05, q};
      e[1] = e[1] | (exc ? 8'h80 : 8'h00);
      addCrc(e);
      i_mbrtu_master_model.rxQ = {};
      i_mbrtu_master_model.stopBad = 0;
      doneCnt = 0;
      respExc = exc;
      foreach (q[i]) begin
         respData = q[i];
         respLast = (i == q.size() - 1);
         respValid = 1'b1;
         waitCnt(numChecks, 0, "payload");
         #1;
         for (int k = 0; k < 8000 && !respReady; k++) @(negedge mclk) #1;
         if (!respReady) begin
            chk("payload taken", 16'h0001, 16'h0000);
            summarize();
         end
         @(negedge mclk);
      end
      respValid = 1'b0;
      waitCnt(doneCnt, 1, "reply done");
      repeat (10) @(negedge mclk);
      chk("reply length", 16'(e.size()), 16'(i_mbrtu_master_model.rxQ.size()));
      foreach (e[i]) chk("reply byte", {8'h00, e[i]}, {8'h00, i_mbrtu_master_model.rxQ[i]});
      chk("stop bits", 16'h0000, 16'(i_mbrtu_master_model.stopBad));
   endtask
   task automatic ownFast();
      request({8'h05, 8'h03, 8'h00, 8'h78, 8'h00, 8'h02}, 1, -1, 1, 7, 1'b1, 1'b0);
      reply({8'h03, 8'h02, 8'h12, 8'h34}, 1'b0);
   endtask
   task automatic ownSlowExc();
      baudSel = 4'h8;
      i_mbrtu_master_model.bitCyc = 48;
      request({8'h05, 8'h06, 8'h01, 8'h14, 8'hab, 8'hcd}, 2, -1, 1, 7, 1'b1, 1'b0);
      reply({8'h06, 8'h02}, 1'b1);
      baudSel = 4'h9;
      i_mbrtu_master_model.bitCyc = 32;
   endtask
   task automatic bcastQuiet();
      request({8'h00, 8'h06, 8'h00, 8'h10, 8'h00, 8'h01}, 1, -1, 1, 7, 1'b1, 1'b1);
      i_mbrtu_master_model.rxQ = {};
      toCnt = 0;
      respData = 8'h06;
      respValid = 1'b1;
      repeat (6900) @(negedge mclk);
      respValid = 1'b0;
      chk("broadcast reply", 16'h0000, 16'(i_mbrtu_master_model.rxQ.size()));
      chk("broadcast window", 16'h0000, 16'(toCnt));
   endtask
   task automatic timeoutWin();
      maxRespBits = 16'h0028;
      toCnt = 0;
      request({8'h05, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01}, 1, -1, 1, 7, 1'b1, 1'b0);
      // Ten bit times of frozen clock enable must stretch the window by as much
      repeat (100) @(negedge mclk);
      ce = 1'b0;
      repeat (320) @(negedge mclk);
      ce = 1'b1;
      waitCnt(toCnt, 1, "response timeout");
      chk("timeout span", 16'h0001, {15'h0000, (toCyc - endCyc) >= 1600 && (toCyc - endCyc) <= 1640});
      maxRespBits = 16'h00c8;
   endtask
   initial begin
      repeat (20) @(negedge mclk);
      rst_b = 1'b1;
      ownFast();
      ownSlowExc();
      bcastQuiet();
      request({8'h09, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01}, 1, -1, 1, 0, 1'b0, 1'b0);
      request({8'h05, 8'h03, 8'h00, 8'h78, 8'h00, 8'h02}, 1, 3, 2, 2, 1'b0, 1'b0);
      timeoutWin();
      summarize();
   end
endmodule // modbus_rtu_slave_framer_tb
`default_nettype wire
